// File: rtl/scc_control.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] a conversion starts only on a low conversion_start_n, nothing else starts one.
// [R2] the conversion phase begins at the falling edge of conversion_start_n after acquisition.
// [R3] a running conversion always completes; new starts and power_down_request cannot abort it.
// [R4] conversion timing ignores chip select and read strobe entirely.
// [R5] at the end of the sequence the result code is produced and busy is driven low.
// [R6] if conversion_start_n is still low when busy falls, acquisition and the next start run by themselves.
// [R7] the self-repeating rate may exceed the nominal rate, so the result path takes any rate.
// [R8] after power-up the host must drive conversion_start_n low once to begin converting.
// [R9] the core drops to low power at the end of every conversion and stays so through acquisition.
// [R10] the host interface stays fully working during acquisition and low power.
// [R11] ref_buffer_power_down low enables the reference buffer, high powers it down.
// [R12] busy stays high from start to result, for a length set by the conversion clock.
module scc_control
  import scc_pkg::*;
#(
  parameter int unsigned CONV_LEN = CONV_CYCLES,
  parameter int unsigned ACQ_LEN  = ACQ_CYCLES
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // conversion control pins
  input  wire logic                    conversion_start_n,
  input  wire logic                    cs_n,
  input  wire logic                    rd_n,
  // result from the sar core
  input  wire logic [RESULT_WIDTH-1:0] sar_code,
  // converter status pins
  output logic                         busy,
  output logic                         core_low_power,
  output logic                         ref_buffer_power_down,
  output logic                         ref_buffer_enable,
  output logic                         result_valid,
  output logic [RESULT_WIDTH-1:0]      result_data,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  scc_state_type          state_reg;
  logic [CNT_WIDTH-1:0]   cnt_reg;
  logic                   start_lvl;
  logic                   start_prev_reg;
  logic                   start_fall;
  logic                   armed_reg;
  logic                   auto_reg;
  logic [1:0]             ctrl_reg;
  logic [31:0]            conv_count_reg;
  logic                   apb_write;
  logic                   apb_read;
  logic                   addr_ok;

  // cycle counts cut to counter width
  function automatic logic [CNT_WIDTH-1:0] len_of(input int unsigned n);
    len_of = CNT_WIDTH'((n > 0) ? n - 1 : 0);
  endfunction

  // ==========================================================================
  // start pin
  // ==========================================================================
  // start pin crosses from the host domain
  scc_sync #(
    .RESET_LEVEL (1'b1)
  ) u_start_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_in    (conversion_start_n),
    .level_out (start_lvl)
  );

  // falling edge of the synchronised start level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_prev_reg <= 1'b1;
    end else begin
      start_prev_reg <= start_lvl;
    end
  end

  assign start_fall = start_prev_reg & ~start_lvl; // [R2]

  // nothing converts until the host first pulls start low after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (start_fall) begin
      armed_reg <= 1'b1; // [R8]
    end
  end

  // ==========================================================================
  // conversion sequencer; cs_n and rd_n are never looked at here
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= SCC_IDLE;
      cnt_reg   <= '0;
      auto_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        SCC_IDLE: begin
          if (start_fall) begin // [R1] [R2] [R4]
            state_reg <= SCC_CONVERT;
            cnt_reg   <= len_of(CONV_LEN);
            auto_reg  <= 1'b0;
          end
        end
        SCC_CONVERT: begin
          // runs to the end regardless of start or power down [R3] [R12]
          if (cnt_reg == '0) begin
            if (!start_lvl) begin
              state_reg <= SCC_ACQUIRE; // [R6]
              cnt_reg   <= len_of(ACQ_LEN);
              auto_reg  <= 1'b1;
            end else begin
              state_reg <= SCC_IDLE;
              auto_reg  <= 1'b0;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SCC_ACQUIRE: begin
          // self-timed acquisition, restart if start still low
          if (start_lvl) begin
            state_reg <= SCC_IDLE;
            auto_reg  <= 1'b0;
          end else if (cnt_reg == '0) begin
            state_reg <= SCC_CONVERT; // [R6]
            cnt_reg   <= len_of(CONV_LEN);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  assign busy           = (state_reg == SCC_CONVERT); // [R12] [R5]
  assign core_low_power = (state_reg != SCC_CONVERT); // [R9]

  // ==========================================================================
  // result capture
  // ==========================================================================
  // result taken each time busy falls; no rate limit on the output side
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_data  <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (state_reg == SCC_CONVERT && cnt_reg == '0) begin
        result_data  <= sar_code; // [R5] [R7]
        result_valid <= 1'b1;
      end
    end
  end

  // completed conversion counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conv_count_reg <= '0;
    end else if (state_reg == SCC_CONVERT && cnt_reg == '0) begin
      conv_count_reg <= conv_count_reg + 32'h1;
    end
  end

  // ==========================================================================
  // apb slave, always answers, also during acquisition
  // ==========================================================================
  assign apb_write = psel & penable & pwrite;
  assign apb_read  = psel & ~pwrite;
  assign addr_ok   = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) ||
                     (paddr == RESULT_ADDR) || (paddr == COUNT_ADDR);
  assign pready    = 1'b1; // [R10]
  assign pslverr   = psel & penable & ~addr_ok;

  // control register; power down request only steers software view
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET_VALUE;
    end else if (apb_write && paddr == CTRL_ADDR) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // buffer enable follows the software level [R11]
  assign ref_buffer_power_down = ctrl_reg[CTRL_BUF_PD_BIT];
  assign ref_buffer_enable     = ~ctrl_reg[CTRL_BUF_PD_BIT]; // [R11]

  // read data registered in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (apb_read && !penable) begin
      unique case (paddr)
        CTRL_ADDR:   prdata <= {30'h0, ctrl_reg};
        STATUS_ADDR: prdata <= {28'h0, armed_reg, auto_reg, core_low_power, busy};
        RESULT_ADDR: prdata <= {14'h0, result_data};
        COUNT_ADDR:  prdata <= conv_count_reg;
        default:     prdata <= '0;
      endcase
    end
  end

endmodule // scc_control
`default_nettype wire

// File: rtl/scc_pkg.sv
// ==========================================================================
// sar conversion control constants
// ==========================================================================
package scc_pkg;

  localparam int unsigned SYS_CLK_HZ        = 20000000;
  localparam int unsigned RESULT_WIDTH      = 18;
  // conversion phase length in ns; internal conversion clock figure
  localparam int unsigned CONV_TIME_NS      = 1500;
  localparam int unsigned CONV_CYCLES       =
      (CONV_TIME_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  // automatic acquisition time between conversions in ns
  localparam int unsigned ACQ_TIME_NS       = 250;
  localparam int unsigned ACQ_CYCLES        =
      (ACQ_TIME_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_WIDTH         = 8;

  // ==========================================================================
  // apb register map
  // ==========================================================================
  localparam logic [11:0] CTRL_ADDR         = 12'h000;
  localparam logic [11:0] STATUS_ADDR       = 12'h004;
  localparam logic [11:0] RESULT_ADDR       = 12'h008;
  localparam logic [11:0] COUNT_ADDR        = 12'h00c;

  // control fields
  localparam int unsigned CTRL_PD_BIT       = 0;
  localparam int unsigned CTRL_BUF_PD_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET_VALUE  = 2'h0;

  // status fields
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_LOWPWR_BIT   = 1;
  localparam int unsigned STAT_AUTO_BIT     = 2;
  localparam int unsigned STAT_ARMED_BIT    = 3;

  typedef enum logic [1:0] {
    SCC_IDLE,
    SCC_CONVERT,
    SCC_ACQUIRE
  } scc_state_type;

endpackage : scc_pkg

// File: rtl/scc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// three-stage pin synchroniser, change taken when stages two and three agree
// ==========================================================================
module scc_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // pin and result
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage_reg;

  // shift the pin through three flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage_reg <= {3{RESET_LEVEL}};
    end else begin
      stage_reg <= {stage_reg[1:0], pin_in};
    end
  end

  // accept a new level once the two later stages agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level_out <= RESET_LEVEL;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_out <= stage_reg[2];
    end
  end

endmodule // scc_sync
`default_nettype wire

// File: tb/scc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// conversion sequencing checker
// ==========================================================================
module scc_monitor
  import scc_pkg::*;
#(
  parameter int unsigned CONV_LEN = 30
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  // conversion pins
  input wire logic                    conversion_start_n,
  input wire logic                    busy,
  input wire logic                    core_low_power,
  input wire logic                    ref_buffer_power_down,
  input wire logic                    ref_buffer_enable,
  input wire logic                    result_valid,
  input wire logic [RESULT_WIDTH-1:0] result_data,
  // apb handshake
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready
);
  logic [7:0] busy_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // counts cycles of one busy pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !busy) busy_cnt <= 8'h00;
    else busy_cnt <= busy_cnt + 8'h01;
  end
  sequence s_fall; $fell(busy); endsequence
  sequence s_held; !conversion_start_n && !$past(conversion_start_n, 3); endsequence
  AST_START: assert property ($rose(busy) |-> !$past(conversion_start_n, 3))
    else $error("busy rose without a start request");
  AST_LEN: assert property (s_fall |-> busy_cnt == CONV_LEN)
    else $error("busy pulse length wrong");
  AST_GAP: assert property (s_fall |=> !busy [*3])
    else $error("conversion restarted without acquisition");
  AST_DONE: assert property (s_fall |-> result_valid)
    else $error("no result after busy fell");
  AST_CAUSE: assert property (result_valid |-> !busy && $past(busy))
    else $error("result without finished conversion");
  AST_HOLD: assert property (!result_valid |-> $stable(result_data))
    else $error("result data changed without valid");
  AST_AUTO: assert property (s_fall ##0 s_held |-> ##[3:8] busy)
    else $error("held start did not repeat");
  AST_LOWPWR: assert property (core_low_power == !busy)
    else $error("low power state wrong");
  AST_BUF: assert property (ref_buffer_enable == !ref_buffer_power_down)
    else $error("buffer enable not inverse");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("apb not ready");
endmodule // scc_monitor
bind scc_control scc_monitor #(.CONV_LEN(CONV_LEN)) i_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .conversion_start_n(conversion_start_n),
  .busy(busy), .core_low_power(core_low_power), .result_valid(result_valid),
  .ref_buffer_power_down(ref_buffer_power_down), .ref_buffer_enable(ref_buffer_enable),
  .result_data(result_data), .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire

// File: tb/scc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host side: start pin and free-running read strobes
// ==========================================================================
module scc_host_model (
  // clock
  input  wire logic sys_clk,
  // host pins
  output logic      conversion_start_n,
  output logic      cs_n,
  output logic      rd_n
);
  logic [1:0] tog = 2'h0;
  initial conversion_start_n = 1'b1;
  // strobes toggle all the time, conversion must ignore them
  always @(posedge sys_clk) tog <= tog + 2'h1;
  assign cs_n = tog[1];
  assign rd_n = tog[0];
  // start pin level, pulled low at least once after power-up
  task automatic set_pin(input logic lvl);
    conversion_start_n <= lvl;
  endtask
endmodule // scc_host_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// testbench
// ==========================================================================
module tb;
  import scc_pkg::*;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, pb;
  logic conversion_start_n, cs_n, rd_n, busy, core_low_power, result_valid;
  logic ref_buffer_power_down, ref_buffer_enable;
  logic [RESULT_WIDTH-1:0] sar_code, result_data;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int errors, n_compared, n_res, cycles, seed, k;
  int exp_q[$];
  scc_control #(.CONV_LEN(30), .ACQ_LEN(5)) i_dut (.sys_clk, .rst_n, .conversion_start_n,
    .cs_n, .rd_n, .sar_code, .busy, .core_low_power, .ref_buffer_power_down,
    .ref_buffer_enable, .result_valid, .result_data, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  scc_host_model i_host (.sys_clk, .conversion_start_n, .cs_n, .rd_n);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) errors++; // bus hang counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // wait until busy has stayed low a while
  task automatic settle;
    int q = 0;
    repeat (400) begin
      @(posedge sys_clk);
      q = (busy === 1'b0) ? q + 1 : 0;
      if (q == 20) break;
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // model check of every finished conversion
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
    if (rst_n && result_valid === 1'b1) begin
      n_res++;
      chk("result", exp_q.size() ? exp_q.pop_front() : -1, 32'(result_data));
    end
  end
  initial begin
    seed = 32'hc5c5eb01;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = $random(seed);
    sar_code = $random(seed);
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", 32'h2, rd & 32'h3);
    $display("reset test done");
    // single start, power-down and a second edge while busy
    v = $random(seed);
    sar_code <= v[17:0];
    exp_q.push_back(v[17:0]);
    i_host.set_pin(1'b0);
    repeat (8) @(posedge sys_clk);
    i_host.set_pin(1'b1);
    apb(1'b1, CTRL_ADDR, 32'h1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("busy", 32'h1, rd & 32'h3);
    i_host.set_pin(1'b0);
    repeat (8) @(posedge sys_clk);
    i_host.set_pin(1'b1);
    settle();
    chk("single", 32'd1, 32'(n_res));
    $display("single test done");
    // held start converts three times
    v = $random(seed);
    sar_code <= v[17:0];
    repeat (3) exp_q.push_back(v[17:0]);
    i_host.set_pin(1'b0);
    k = 0;
    pb = 1'b0;
    repeat (400) begin
      @(posedge sys_clk);
      if (busy && !pb) k++;
      pb = busy;
      if (k == 3) break;
    end
    i_host.set_pin(1'b1);
    settle();
    chk("auto", 32'd4, 32'(n_res));
    apb(1'b0, COUNT_ADDR, 32'h0);
    chk("count", 32'd4, rd);
    $display("auto test done");
    // second reset in mid-run clears counter and status
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, COUNT_ADDR, $random(seed));
    chk("count_rst", 32'd0, rd);
    apb(1'b0, STATUS_ADDR, $random(seed));
    chk("status_rst", 32'h2, rd);
    $display("reset again test done");
    // reference buffer and an unmapped read
    apb(1'b1, CTRL_ADDR, 32'h2);
    chk("bufpd", 32'h1, 32'(ref_buffer_power_down));
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h2, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    $display("register test done");
    results();
  end
endmodule // tb
`default_nettype wire
